// [logic/lsi_line_status.sv]
// line status and interrupt block with ahb-lite register slave
`timescale 1ns/1ps
module lsi_line_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic driver_fault_in,
  input wire logic signal_absent_in,
  input wire logic [4:0] gain_in,
  input wire logic [6:0] tx_spacing_in,
  input wire logic [6:0] rx_spacing_in,
  input wire logic template_overflow_ev,
  input wire logic tx_fifo_err_ev,
  input wire logic rx_fifo_err_ev,
  input wire logic zero_run_ev,
  input wire logic bipolar_err_ev,
  output logic irq
);
  logic [7:0] irq_en_a;
  logic [7:0] irq_en_b;
  logic [7:0] edge_sel;
  logic [7:0] line_ctrl;
  logic driver_fault_live;
  logic signal_absent_live;
  logic [4:0] equalizer_gain_code;
  logic [6:0] tx_pointer_spacing;
  logic [6:0] rx_pointer_spacing;
  logic [15:0] zero_run_count;
  logic wr_pend;
  logic [11:0] addr_q;
  logic [7:0] flags_a;
  logic [7:0] flags_b;

  function automatic logic sel_hit(input logic [11:0] a, input logic [11:0] o);
    sel_hit = (a == o);
  endfunction

  function automatic logic [6:0] next_spacing(input logic peak,
                                              input logic [6:0] held,
                                              input logic [6:0] live);
    if (!peak) begin
      next_spacing = live;
    end else if (live > held) begin
      next_spacing = live;
    end else begin
      next_spacing = held;
    end
  endfunction

  // address phase capture
  wire addr_ok = hsel && hready && htrans[1];
  wire do_wr = wr_pend;
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_en_a = do_wr && sel_hit(addr_q, lsi_pkg::OFF_IRQ_EN_A);
  wire wr_en_b = do_wr && sel_hit(addr_q, lsi_pkg::OFF_IRQ_EN_B);
  wire wr_edge = do_wr && sel_hit(addr_q, lsi_pkg::OFF_EDGE_SEL);
  wire wr_ctrl = do_wr && sel_hit(addr_q, lsi_pkg::OFF_LINE_CTRL);
  wire wr_flag_a = do_wr && sel_hit(addr_q, lsi_pkg::OFF_FLAGS_A);
  wire wr_flag_b = do_wr && sel_hit(addr_q, lsi_pkg::OFF_FLAGS_B);
  wire wr_tx_jit = do_wr && sel_hit(addr_q, lsi_pkg::OFF_TX_JITTER);
  wire wr_rx_jit = do_wr && sel_hit(addr_q, lsi_pkg::OFF_RX_JITTER);
  // reads decode the address phase, so the value shown is the one held
  // just before the peak restarts from the live spacing
  wire [11:0] rd_addr = {haddr[11:2], 2'b00};
  wire rd_start = addr_ok && !hwrite;
  wire rd_tx_jit = rd_start && sel_hit(rd_addr, lsi_pkg::OFF_TX_JITTER);
  wire rd_rx_jit = rd_start && sel_hit(rd_addr, lsi_pkg::OFF_RX_JITTER);

  wire tx_peak_measure_sel = line_ctrl[lsi_pkg::BIT_TX_PEAK_SEL];
  wire rx_peak_measure_sel = line_ctrl[lsi_pkg::BIT_RX_PEAK_SEL];
  wire [1:0] zero_run_count_en =
    line_ctrl[lsi_pkg::BIT_COUNT_EN_LO +: 2];
  wire driver_fault_edge_sel = edge_sel[lsi_pkg::BIT_DRIVER];
  wire signal_absent_edge_sel = edge_sel[lsi_pkg::BIT_SIGNAL];

  // edge qualification; live bits are registered so a change shows here
  wire driver_rise = driver_fault_in && !driver_fault_live;
  wire driver_any = driver_fault_in != driver_fault_live;
  wire signal_rise = signal_absent_in && !signal_absent_live;
  wire signal_any = signal_absent_in != signal_absent_live;
  wire driver_set = driver_fault_edge_sel ? driver_any : driver_rise;
  wire signal_set = signal_absent_edge_sel ? signal_any : signal_rise;

  wire count_on = zero_run_ev && (zero_run_count_en == lsi_pkg::COUNT_EN_CODE);
  wire wrap_ev = count_on && (zero_run_count == 16'hFFFF);

  wire [7:0] set_a;
  wire [7:0] set_b;
  assign set_a = {5'h00, driver_set, 1'b0, signal_set};
  assign set_b = {1'b0, template_overflow_ev, tx_fifo_err_ev,
                  rx_fifo_err_ev, 1'b0, zero_run_ev,
                  bipolar_err_ev, wrap_ev};

  // sticky flags, only implemented bits exist so reserved read 0
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flags
      if (lsi_pkg::MASK_A[gi]) begin : g_a
        lsi_sticky u_a (
          .hclk(hclk),
          .hresetn(hresetn),
          .set(set_a[gi]),
          .clear(wr_flag_a && wbyte[gi]),
          .flag(flags_a[gi])
        );
      end else begin : g_az
        assign flags_a[gi] = 1'b0;
      end
      if (lsi_pkg::MASK_B[gi]) begin : g_b
        lsi_sticky u_b (
          .hclk(hclk),
          .hresetn(hresetn),
          .set(set_b[gi]),
          .clear(wr_flag_b && wbyte[gi]),
          .flag(flags_b[gi])
        );
      end else begin : g_bz
        assign flags_b[gi] = 1'b0;
      end
    end
  endgenerate

  // driver/signal gated by enable a, others by enable b
  wire next_irq = |(flags_a & irq_en_a)
                | |(flags_b & irq_en_b);

  wire [7:0] rd_mux =
    sel_hit(rd_addr, lsi_pkg::OFF_IRQ_EN_A) ? irq_en_a :
    sel_hit(rd_addr, lsi_pkg::OFF_IRQ_EN_B) ? irq_en_b :
    sel_hit(rd_addr, lsi_pkg::OFF_EDGE_SEL) ? edge_sel :
    sel_hit(rd_addr, lsi_pkg::OFF_LINE_CTRL) ? line_ctrl :
    sel_hit(rd_addr, lsi_pkg::OFF_LINE_COND) ?
      {5'h00, driver_fault_live, 1'b0, signal_absent_live} :
    sel_hit(rd_addr, lsi_pkg::OFF_EQ_GAIN) ? {3'h0, equalizer_gain_code} :
    sel_hit(rd_addr, lsi_pkg::OFF_TX_JITTER) ? {1'b0, tx_pointer_spacing} :
    sel_hit(rd_addr, lsi_pkg::OFF_RX_JITTER) ? {1'b0, rx_pointer_spacing} :
    sel_hit(rd_addr, lsi_pkg::OFF_FLAGS_A) ? flags_a :
    sel_hit(rd_addr, lsi_pkg::OFF_FLAGS_B) ? flags_b :
    lsi_pkg::RESET_BYTE;

  // gain codes above 10101 all mean the top band, so fold them
  wire [4:0] next_gain = (gain_in > lsi_pkg::GAIN_CODE_MAX) ?
    lsi_pkg::GAIN_CODE_MAX : gain_in;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      if (hready) begin
        wr_pend <= addr_ok && hwrite;
        addr_q <= {haddr[11:2], 2'b00};
      end
    end
  end

  // zero-wait slave: data phase is one cycle, always OKAY
  // read data loads at the address phase so it stands in the data phase;
  // a read pipelined right behind a write to that register sees old data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_start) hrdata <= {24'h000000, rd_mux};
    end
  end

  // registers written by software; reserved bits masked off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_a <= lsi_pkg::RESET_BYTE;
      irq_en_b <= lsi_pkg::RESET_BYTE;
      edge_sel <= lsi_pkg::RESET_BYTE;
      line_ctrl <= lsi_pkg::RESET_BYTE;
    end else begin
      if (wr_en_a) irq_en_a <= wbyte & lsi_pkg::MASK_A;
      if (wr_en_b) irq_en_b <= wbyte & lsi_pkg::MASK_B;
      if (wr_edge) edge_sel <= wbyte & lsi_pkg::MASK_A;
      if (wr_ctrl) line_ctrl <= wbyte & lsi_pkg::MASK_CTRL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      driver_fault_live <= 1'b0;
      signal_absent_live <= 1'b0;
      equalizer_gain_code <= 5'h00;
      irq <= 1'b0;
      zero_run_count <= 16'h0000;
    end else begin
      driver_fault_live <= driver_fault_in;
      signal_absent_live <= signal_absent_in;
      equalizer_gain_code <= next_gain;
      irq <= next_irq;
      if (count_on) zero_run_count <= zero_run_count + 16'h0001;
    end
  end

  // a read in peak mode restarts the peak from the present spacing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pointer_spacing <= 7'h00;
      rx_pointer_spacing <= 7'h00;
    end else begin
      if (wr_tx_jit && wbyte[0]) begin
        tx_pointer_spacing <= 7'h00;
      end else if (rd_tx_jit && tx_peak_measure_sel) begin
        tx_pointer_spacing <= tx_spacing_in;
      end else begin
        tx_pointer_spacing <= next_spacing(tx_peak_measure_sel,
                                           tx_pointer_spacing, tx_spacing_in);
      end
      if (wr_rx_jit && wbyte[0]) begin
        rx_pointer_spacing <= 7'h00;
      end else if (rd_rx_jit && rx_peak_measure_sel) begin
        rx_pointer_spacing <= rx_spacing_in;
      end else begin
        rx_pointer_spacing <= next_spacing(rx_peak_measure_sel,
                                           rx_pointer_spacing, rx_spacing_in);
      end
    end
  end

  // assertions
  a_irq_follows_flags: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == $past(next_irq))
    else $error("irq does not follow enabled flags");
  a_masked_no_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (irq_en_a == 8'h00 && irq_en_b == 8'h00) |=> !irq)
    else $error("irq raised with all enables low");
  a_enabled_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|(flags_a & irq_en_a) || |(flags_b & irq_en_b)) |=> irq)
    else $error("enabled flag did not raise irq");
  a_rise_sets_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (driver_fault_in && !driver_fault_live)
      |=> flags_a[lsi_pkg::BIT_DRIVER])
    else $error("driver rise did not set flag");
  a_fall_ignored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!driver_fault_edge_sel && !driver_fault_in && driver_fault_live &&
      !flags_a[lsi_pkg::BIT_DRIVER]) |=> !flags_a[lsi_pkg::BIT_DRIVER])
    else $error("driver fall set flag with rising edge selected");
  a_fall_edge_sel: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!signal_absent_in && signal_absent_live && signal_absent_edge_sel)
      |=> flags_a[lsi_pkg::BIT_SIGNAL])
    else $error("signal fall with edge sel did not set flag");
  a_flag_sticks: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flags_b[lsi_pkg::BIT_BIPOLAR] &&
      !(wr_flag_b && wbyte[lsi_pkg::BIT_BIPOLAR]))
      |=> flags_b[lsi_pkg::BIT_BIPOLAR])
    else $error("bipolar flag dropped without clear");
  a_clear_works: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_flag_b && wbyte[lsi_pkg::BIT_ZERO_RUN] && !zero_run_ev)
      |=> !flags_b[lsi_pkg::BIT_ZERO_RUN])
    else $error("zero-run flag not cleared");
  a_gain_fold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (gain_in > lsi_pkg::GAIN_CODE_MAX)
      |=> equalizer_gain_code == lsi_pkg::GAIN_CODE_MAX)
    else $error("gain code not folded");
  a_gain_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (gain_in <= lsi_pkg::GAIN_CODE_MAX)
      |=> equalizer_gain_code == $past(gain_in))
    else $error("gain code not passed through");
  a_jitter_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_tx_jit && wbyte[0]) |=> tx_pointer_spacing == 7'h00)
    else $error("tx spacing not cleared");
  a_rx_jitter_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_rx_jit && wbyte[0]) |=> rx_pointer_spacing == 7'h00)
    else $error("rx spacing not cleared");
  a_live_spacing: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!rx_peak_measure_sel && !(wr_rx_jit && wbyte[0]))
      |=> rx_pointer_spacing == $past(rx_spacing_in))
    else $error("rx spacing does not follow live value");
  a_peak_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tx_peak_measure_sel && !rd_tx_jit && !(wr_tx_jit && wbyte[0]))
      |=> tx_pointer_spacing >= $past(tx_pointer_spacing))
    else $error("tx peak spacing dropped");
  a_count_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (zero_run_count_en != lsi_pkg::COUNT_EN_CODE)
      |=> $stable(zero_run_count))
    else $error("counter moved while disabled");
  a_wrap_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (count_on && zero_run_count == 16'hFFFF)
      |=> flags_b[lsi_pkg::BIT_WRAP])
    else $error("counter wrap flag not set");
  a_fifo_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_fifo_err_ev |=> flags_b[lsi_pkg::BIT_TX_FIFO])
    else $error("tx fifo flag not set");
  a_rx_fifo_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_fifo_err_ev |=> flags_b[lsi_pkg::BIT_RX_FIFO])
    else $error("rx fifo flag not set");
  a_template_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    template_overflow_ev |=> flags_b[lsi_pkg::BIT_TEMPLATE])
    else $error("template flag not set");
  a_zero_run_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    zero_run_ev |=> flags_b[lsi_pkg::BIT_ZERO_RUN])
    else $error("zero-run flag not set");
  a_bipolar_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    bipolar_err_ev |=> flags_b[lsi_pkg::BIT_BIPOLAR])
    else $error("bipolar flag not set");
  a_reserved_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((irq_en_b & ~lsi_pkg::MASK_B) == 8'h00) &&
      ((edge_sel & ~lsi_pkg::MASK_A) == 8'h00))
    else $error("reserved enable or edge bits set");
endmodule

// [logic/lsi_pkg.sv]
// package: register map, field positions and reset values for line status irq
package lsi_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [11:0] IDX_IRQ_EN_A = 12'h033;
  localparam logic [11:0] IDX_IRQ_EN_B = 12'h034;
  localparam logic [11:0] IDX_EDGE_SEL = 12'h035;
  localparam logic [11:0] IDX_LINE_COND = 12'h036;
  localparam logic [11:0] IDX_EQ_GAIN = 12'h037;
  localparam logic [11:0] IDX_TX_JITTER = 12'h038;
  localparam logic [11:0] IDX_RX_JITTER = 12'h039;
  localparam logic [11:0] IDX_FLAGS_A = 12'h03A;
  localparam logic [11:0] IDX_FLAGS_B = 12'h03B;
  localparam logic [11:0] IDX_LINE_CTRL = 12'h040;
  localparam logic [11:0] OFF_IRQ_EN_A = IDX_IRQ_EN_A << 2;
  localparam logic [11:0] OFF_IRQ_EN_B = IDX_IRQ_EN_B << 2;
  localparam logic [11:0] OFF_EDGE_SEL = IDX_EDGE_SEL << 2;
  localparam logic [11:0] OFF_LINE_COND = IDX_LINE_COND << 2;
  localparam logic [11:0] OFF_EQ_GAIN = IDX_EQ_GAIN << 2;
  localparam logic [11:0] OFF_TX_JITTER = IDX_TX_JITTER << 2;
  localparam logic [11:0] OFF_RX_JITTER = IDX_RX_JITTER << 2;
  localparam logic [11:0] OFF_FLAGS_A = IDX_FLAGS_A << 2;
  localparam logic [11:0] OFF_FLAGS_B = IDX_FLAGS_B << 2;
  localparam logic [11:0] OFF_LINE_CTRL = IDX_LINE_CTRL << 2;
  localparam int BIT_DRIVER = 2;
  localparam int BIT_SIGNAL = 0;
  localparam int BIT_TEMPLATE = 6;
  localparam int BIT_TX_FIFO = 5;
  localparam int BIT_RX_FIFO = 4;
  localparam int BIT_ZERO_RUN = 2;
  localparam int BIT_BIPOLAR = 1;
  localparam int BIT_WRAP = 0;
  localparam int BIT_TX_PEAK_SEL = 5;
  localparam int BIT_RX_PEAK_SEL = 6;
  localparam int BIT_COUNT_EN_LO = 2;
  localparam logic [7:0] MASK_A = 8'h05;
  localparam logic [7:0] MASK_B = 8'h77;
  localparam logic [7:0] MASK_CTRL = 8'h6C;
  localparam logic [7:0] MASK_SPACING = 8'h7F;
  localparam logic [7:0] MASK_GAIN = 8'h1F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] COUNT_EN_CODE = 2'h1;
  localparam logic [4:0] GAIN_CODE_MAX = 5'h15;
endpackage

// [logic/lsi_sticky.sv]
// sticky write-one-to-clear flag with set priority
`timescale 1ns/1ps
module lsi_sticky (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1; // set beats clear
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

// [tb/line_interface_status_irq_bench.sv]
// self-checking bench for the line status and interrupt block
`timescale 1ns/1ps
module line_interface_status_irq_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic drv = 1'b0;
  logic sig = 1'b0;
  logic [4:0] gain = 5'h00;
  logic [6:0] txs = 7'h00;
  logic [6:0] rxs = 7'h00;
  // template, tx fifo, rx fifo, zero run, bipolar
  logic [4:0] ev = 5'h00;
  logic [31:0] q;
  int err_total = 0;
  int cmp_count = 0;

  always #2 hclk = ~hclk;

  lsi_line_status i_lsi_line_status (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .driver_fault_in(drv), .signal_absent_in(sig),
    .gain_in(gain), .tx_spacing_in(txs), .rx_spacing_in(rxs),
    .template_overflow_ev(ev[4]), .tx_fifo_err_ev(ev[3]),
    .rx_fifo_err_ev(ev[2]), .zero_run_ev(ev[1]),
    .bipolar_err_ev(ev[0]), .irq(irq)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer; the bus is its own timing, no fixed wait assumed
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string what);
    bus(a, 1'b0, 32'h0);
    check(what, q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic irqc(input logic e);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  task automatic fire(input logic [4:0] m);
    ev <= m;
    @(posedge hclk);
    ev <= 5'h00;
  endtask

  task automatic t_reset;
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h0, "flags_a");
    rdc(lsi_pkg::OFF_FLAGS_B, 32'h0, "flags_b");
    rdc(lsi_pkg::OFF_IRQ_EN_B, 32'h0, "en_b");
    irqc(1'b0);
    wr(lsi_pkg::OFF_EDGE_SEL, 32'hFF);
    rdc(lsi_pkg::OFF_EDGE_SEL, 32'h05, "edge_sel");
    wr(lsi_pkg::OFF_EDGE_SEL, 32'h00);
    wr(12'h200, 32'hFF);
    rdc(12'h200, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_edge;
    drv <= 1'b1;
    sig <= 1'b1;
    cyc(3);
    rdc(lsi_pkg::OFF_LINE_COND, 32'h05, "live");
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h05, "rise");
    wr(lsi_pkg::OFF_FLAGS_A, 32'h00);
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h05, "w0");
    wr(lsi_pkg::OFF_FLAGS_A, 32'h05);
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h00, "w1c");
    drv <= 1'b0;
    sig <= 1'b0;
    cyc(3);
    rdc(lsi_pkg::OFF_LINE_COND, 32'h00, "live0");
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h00, "fall0");
    wr(lsi_pkg::OFF_EDGE_SEL, 32'h05);
    drv <= 1'b1;
    sig <= 1'b1;
    cyc(3);
    wr(lsi_pkg::OFF_FLAGS_A, 32'h05);
    drv <= 1'b0;
    sig <= 1'b0;
    cyc(3);
    rdc(lsi_pkg::OFF_FLAGS_A, 32'h05, "fall1");
    wr(lsi_pkg::OFF_IRQ_EN_A, 32'h05);
    cyc(2);
    irqc(1'b1);
    wr(lsi_pkg::OFF_IRQ_EN_A, 32'h01);
    wr(lsi_pkg::OFF_FLAGS_A, 32'h01);
    cyc(2);
    irqc(1'b0);
    wr(lsi_pkg::OFF_FLAGS_A, 32'h04);
    wr(lsi_pkg::OFF_IRQ_EN_A, 32'h00);
    $display("test edge done");
  endtask

  task automatic t_events;
    logic [7:0] bm [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
    fire(5'h1F);
    cyc(3);
    rdc(lsi_pkg::OFF_FLAGS_B, 32'h76, "all");
    irqc(1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(lsi_pkg::OFF_FLAGS_B, 32'hFF);
      wr(lsi_pkg::OFF_IRQ_EN_B, {24'h0, bm[i]});
      fire(5'(1 << i));
      cyc(3);
      rdc(lsi_pkg::OFF_FLAGS_B, {24'h0, bm[i]}, "one");
      irqc(1'b1);
      wr(lsi_pkg::OFF_IRQ_EN_B, {24'h0, ~bm[i]});
      cyc(2);
      irqc(1'b0);
    end
    wr(lsi_pkg::OFF_FLAGS_B, 32'hFF);
    wr(lsi_pkg::OFF_IRQ_EN_B, 32'h00);
    $display("test events done");
  endtask

  task automatic t_gain;
    logic [4:0] c [4] = '{5'h00, 5'h14, 5'h15, 5'h1F};
    for (int i = 0; i < 4; i++) begin
      gain <= c[i];
      cyc(2);
      rdc(lsi_pkg::OFF_EQ_GAIN, (c[i] > 5'h15) ? 32'h15 : {27'h0, c[i]},
          "gain");
    end
    $display("test gain done");
  endtask

  task automatic t_jitter;
    txs <= 7'h33;
    rxs <= 7'h2A;
    cyc(2);
    rdc(lsi_pkg::OFF_TX_JITTER, 32'h33, "tx now");
    rdc(lsi_pkg::OFF_RX_JITTER, 32'h2A, "rx now");
    wr(lsi_pkg::OFF_LINE_CTRL, 32'h60);
    bus(lsi_pkg::OFF_TX_JITTER, 1'b0, 32'h0);
    bus(lsi_pkg::OFF_RX_JITTER, 1'b0, 32'h0);
    txs <= 7'h50;
    rxs <= 7'h61;
    cyc(2);
    txs <= 7'h05;
    rxs <= 7'h06;
    cyc(2);
    rdc(lsi_pkg::OFF_TX_JITTER, 32'h50, "tx peak");
    rdc(lsi_pkg::OFF_RX_JITTER, 32'h61, "rx peak");
    txs <= 7'h70;
    cyc(2);
    txs <= 7'h05;
    wr(lsi_pkg::OFF_TX_JITTER, 32'h01);
    rdc(lsi_pkg::OFF_TX_JITTER, 32'h00, "tx clear");
    wr(lsi_pkg::OFF_LINE_CTRL, 32'h00);
    $display("test jitter done");
  endtask

  // a long run; zero-run pulses of earlier tests must not have counted
  task automatic t_wrap;
    wr(lsi_pkg::OFF_LINE_CTRL, 32'h04);
    ev <= 5'h02;
    cyc(65535);
    ev <= 5'h00;
    cyc(3);
    rdc(lsi_pkg::OFF_FLAGS_B, 32'h04, "no wrap");
    fire(5'h02);
    cyc(3);
    rdc(lsi_pkg::OFF_FLAGS_B, 32'h05, "wrap");
    wr(lsi_pkg::OFF_IRQ_EN_B, 32'h01);
    cyc(2);
    irqc(1'b1);
    wr(lsi_pkg::OFF_FLAGS_B, 32'h01);
    cyc(2);
    irqc(1'b0);
    $display("test wrap done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_edge;
    t_events;
    t_gain;
    t_jitter;
    t_wrap;
    final_report;
  end

  // the wrap run dominates at about 66k cycles
  initial begin
    #320000;
    err_total++;
    final_report;
  end
endmodule
